//--- nsq_cycle_timer.sv
`timescale 1ns/1ps
module nsq_cycle_timer
   import nsq_pkg::*;
#(
   parameter int W = NSQ_TMR_W
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic load_in,
   input wire logic [W-1:0] count_in,
   output logic expire_out
);

   logic [W-1:0] cnt_r;

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (W < 2) begin : g_bad_w
      $error("nsq_cycle_timer: counter width must be at least two");
   end

   // ------------------------------------------------------------------
   // Down counter: expire is high in the count_in-th cycle after load
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         cnt_r <= '0;
      end else if (load_in) begin
         cnt_r <= count_in;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   assign expire_out = (cnt_r == {{(W-1){1'b0}}, 1'b1}) && !load_in;

endmodule // nsq_cycle_timer

//--- nsq_host.sv
`timescale 1ns/1ps
module nsq_host
   import nsq_pkg::*;
#(
   parameter int RECALL_CYC = NSQ_RECALL_CYC,
   parameter int STORE_CYC = NSQ_STORE_CYC,
   parameter bit BOOT_ASAVE_ON = 1'b1
) (
   input wire logic clk_sys_in,
   input wire logic srst_in,
   // User side
   input wire logic start_in,
   input wire nsq_op_t op_in,
   input wire logic [NSQ_ADDR_W-1:0] addr_in,
   input wire logic [NSQ_DATA_W-1:0] wdata_in,
   input wire logic upper_byte_enable_n_in,
   input wire logic lower_byte_enable_n_in,
   output logic busy_out,
   output logic done_out,
   output logic [NSQ_DATA_W-1:0] rdata_out,
   output logic asave_on_out,
   // Memory side
   output logic chip_sel_n_out,
   output logic write_en_n_out,
   output logic out_en_n_out,
   output logic upper_byte_enable_n_out,
   output logic lower_byte_enable_n_out,
   output logic [NSQ_ADDR_W-1:0] mem_addr_out,
   input wire logic [NSQ_DATA_W-1:0] dq_in,
   output logic [NSQ_DATA_W-1:0] dq_out,
   output logic dq_oe_out,
   input wire logic store_busy_n_in
);

   typedef enum {
      NSQ_S_IDLE,
      NSQ_S_SETUP,
      NSQ_S_STROBE,
      NSQ_S_GAP,
      NSQ_S_NV,
      NSQ_S_BUSYW,
      NSQ_S_SETTLE,
      NSQ_S_FINISH
   } nsq_state_t;

   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (RECALL_CYC < 1 || STORE_CYC < 1) begin : g_bad_cyc
      $error("nsq_host: nonvolatile cycle counts must be at least one");
   end

   nsq_state_t state_r;
   nsq_op_t op_r;
   logic [NSQ_STEP_W-1:0] step_r;
   logic [NSQ_ADDR_W-1:0] uaddr_r;
   logic [NSQ_DATA_W-1:0] wdata_r;
   logic ube_n_r;
   logic lbe_n_r;
   logic boot_pending_r;
   logic busy_r;
   logic done_r;
   logic [NSQ_DATA_W-1:0] rdata_r;
   logic asave_r;
   logic ce_n_r;
   logic we_n_r;
   logic oe_n_r;
   logic mube_n_r;
   logic mlbe_n_r;
   logic [NSQ_ADDR_W-1:0] maddr_r;
   logic [NSQ_DATA_W-1:0] dq_r;
   logic dq_oe_r;
   logic tmr_load;
   logic [NSQ_TMR_W-1:0] tmr_count;
   logic tmr_expire;
   logic seq_last;
   logic take;

   assign seq_last = (step_r == 3'(NSQ_SEQ_LEN - 1));
   // Memory is disabled while it holds its busy line low
   assign take = (state_r == NSQ_S_IDLE) && store_busy_n_in && (start_in || boot_pending_r);

   // ------------------------------------------------------------------
   // Cycle timer
   // ------------------------------------------------------------------
   always_comb begin
      tmr_load = 1'b0;
      tmr_count = NSQ_TMR_W'(NSQ_ACC_CYC);
      if (state_r == NSQ_S_SETUP) begin
         tmr_load = 1'b1;
      end else if (state_r == NSQ_S_GAP && nsq_is_seq(op_r) && seq_last) begin
         tmr_load = 1'b1;
         tmr_count = (op_r == NSQ_OP_RECALL) ? NSQ_TMR_W'(RECALL_CYC) : NSQ_TMR_W'(STORE_CYC);
      end else if (state_r == NSQ_S_BUSYW && store_busy_n_in) begin
         tmr_load = 1'b1;
         tmr_count = NSQ_TMR_W'(NSQ_BUSY_OUT_CYC);
      end
   end

   nsq_cycle_timer #(
      .W(NSQ_TMR_W)
   ) u_timer (
      .clk_sys_in(clk_sys_in),
      .srst_in(srst_in),
      .load_in(tmr_load),
      .count_in(tmr_count),
      .expire_out(tmr_expire)
   );

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         state_r <= NSQ_S_IDLE;
         op_r <= NSQ_OP_READ;
         step_r <= '0;
      end else begin
         case (state_r)
            NSQ_S_IDLE: begin
               if (take) begin
                  op_r <= boot_pending_r ? NSQ_OP_ASAVE_ON : op_in;
                  step_r <= '0;
                  state_r <= NSQ_S_SETUP;
               end
            end
            NSQ_S_SETUP: begin
               state_r <= NSQ_S_STROBE;
            end
            NSQ_S_STROBE: begin
               if (tmr_expire) begin
                  state_r <= NSQ_S_GAP;
               end
            end
            NSQ_S_GAP: begin
               // The sequence runs uninterrupted, so no foreign access aborts it
               if (!nsq_is_seq(op_r)) begin
                  state_r <= NSQ_S_FINISH;
               end else if (!seq_last) begin
                  step_r <= step_r + 1'b1;
                  state_r <= NSQ_S_SETUP;
               end else if (op_r == NSQ_OP_ASAVE_OFF || op_r == NSQ_OP_ASAVE_ON) begin
                  op_r <= NSQ_OP_STORE;
                  step_r <= '0;
                  state_r <= NSQ_S_SETUP;
               end else begin
                  state_r <= NSQ_S_NV;
               end
            end
            NSQ_S_NV: begin
               if (tmr_expire) begin
                  state_r <= NSQ_S_BUSYW;
               end
            end
            NSQ_S_BUSYW: begin
               if (store_busy_n_in) begin
                  state_r <= NSQ_S_SETTLE;
               end
            end
            NSQ_S_SETTLE: begin
               if (tmr_expire) begin
                  state_r <= NSQ_S_FINISH;
               end
            end
            default: begin
               state_r <= NSQ_S_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Request capture and user status
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         uaddr_r <= '0;
         wdata_r <= '0;
         ube_n_r <= 1'b1;
         lbe_n_r <= 1'b1;
         boot_pending_r <= BOOT_ASAVE_ON;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         rdata_r <= '0;
         asave_r <= NSQ_ASAVE_RST;
      end else begin
         done_r <= (state_r == NSQ_S_FINISH);
         if (take) begin
            uaddr_r <= addr_in;
            wdata_r <= wdata_in;
            ube_n_r <= boot_pending_r ? 1'b0 : upper_byte_enable_n_in;
            lbe_n_r <= boot_pending_r ? 1'b0 : lower_byte_enable_n_in;
            boot_pending_r <= 1'b0;
            busy_r <= 1'b1;
         end else if (state_r == NSQ_S_FINISH) begin
            busy_r <= 1'b0;
         end
         if (state_r == NSQ_S_STROBE && tmr_expire && op_r == NSQ_OP_READ) begin
            rdata_r <= dq_in;
         end
         if (state_r == NSQ_S_GAP && seq_last && op_r == NSQ_OP_ASAVE_OFF) begin
            asave_r <= 1'b0;
         end else if (state_r == NSQ_S_GAP && seq_last && op_r == NSQ_OP_ASAVE_ON) begin
            asave_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Memory pins
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         ce_n_r <= 1'b1;
         we_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         mube_n_r <= 1'b1;
         mlbe_n_r <= 1'b1;
         maddr_r <= '0;
         dq_r <= '0;
         dq_oe_r <= 1'b0;
      end else if (state_r == NSQ_S_SETUP) begin
         ce_n_r <= 1'b0;
         if (nsq_is_seq(op_r)) begin
            maddr_r <= nsq_seq_addr(step_r, op_r);
            we_n_r <= 1'b1;
            mube_n_r <= 1'b0;
            mlbe_n_r <= 1'b0;
            // Store and recall leave the bus floating on the command read
            oe_n_r <= seq_last && (op_r == NSQ_OP_STORE || op_r == NSQ_OP_RECALL);
            dq_oe_r <= 1'b0;
         end else begin
            maddr_r <= uaddr_r;
            mube_n_r <= ube_n_r;
            mlbe_n_r <= lbe_n_r;
            we_n_r <= (op_r != NSQ_OP_WRITE);
            oe_n_r <= (op_r == NSQ_OP_WRITE);
            dq_r <= wdata_r;
            dq_oe_r <= (op_r == NSQ_OP_WRITE);
         end
      end else if (state_r == NSQ_S_STROBE && tmr_expire) begin
         ce_n_r <= 1'b1;
         we_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         dq_oe_r <= 1'b0;
      end
   end

   assign busy_out = busy_r;
   assign done_out = done_r;
   assign rdata_out = rdata_r;
   assign asave_on_out = asave_r;
   assign chip_sel_n_out = ce_n_r;
   assign write_en_n_out = we_n_r;
   assign out_en_n_out = oe_n_r;
   assign upper_byte_enable_n_out = mube_n_r;
   assign lower_byte_enable_n_out = mlbe_n_r;
   assign mem_addr_out = maddr_r;
   assign dq_out = dq_r;
   assign dq_oe_out = dq_oe_r;

endmodule // nsq_host

//--- nsq_host_bench.sv
`timescale 1ns/1ps
module nsq_host_bench
   import nsq_pkg::*;
;
   logic clk_sys_in = 1'b0;
   logic srst_in = 1'b1;
   logic start_in = 1'b0;
   logic low_supply = 1'b0;
   logic [1:0] be_n = 2'b00;
   nsq_op_t op_in = NSQ_OP_READ;
   logic [NSQ_ADDR_W-1:0] addr_in = '0;
   logic [NSQ_ADDR_W-1:0] mem_addr;
   logic [NSQ_DATA_W-1:0] wdata_in = '0;
   logic [NSQ_DATA_W-1:0] rdata, dq_h, dq_m, dq_bus;
   logic busy, done, asave_on, cs_n, we_n, oe_n, ube_n, lbe_n, dq_oe, sbusy_n;
   int n_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   always #25 clk_sys_in = ~clk_sys_in;
   assign dq_bus = dq_oe ? dq_h : dq_m;

   nsq_host #(.RECALL_CYC(4), .STORE_CYC(4)) uut (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .start_in(start_in), .op_in(op_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .upper_byte_enable_n_in(be_n[1]), .lower_byte_enable_n_in(be_n[0]), .busy_out(busy),
      .done_out(done), .rdata_out(rdata), .asave_on_out(asave_on), .chip_sel_n_out(cs_n),
      .write_en_n_out(we_n), .out_en_n_out(oe_n), .upper_byte_enable_n_out(ube_n),
      .lower_byte_enable_n_out(lbe_n), .mem_addr_out(mem_addr), .dq_in(dq_bus), .dq_out(dq_h),
      .dq_oe_out(dq_oe), .store_busy_n_in(sbusy_n));
   nsq_mem_model mem (.clk_sys_in(clk_sys_in), .chip_sel_n_in(cs_n), .write_en_n_in(we_n),
      .out_en_n_in(oe_n), .upper_byte_enable_n_in(ube_n), .lower_byte_enable_n_in(lbe_n),
      .addr_in(mem_addr), .dq_in(dq_bus), .dq_out(dq_m), .store_busy_n_out(sbusy_n),
      .low_supply_in(low_supply));

   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         $display("unexpected at %0t: run too long", $time);
         results();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic tick;
      @(posedge clk_sys_in);
      #1;
   endtask

   // ------------------------------------------------------------------
   // One host command, waiting for its completion pulse
   // ------------------------------------------------------------------
   task automatic run(input nsq_op_t o, input logic [NSQ_ADDR_W-1:0] a,
                      input logic [NSQ_DATA_W-1:0] d, input logic [1:0] be = 2'b00);
      int k = 0;
      tick();
      op_in = o;
      addr_in = a;
      wdata_in = d;
      be_n = be;
      start_in = 1'b1;
      while (busy !== 1'b1 && k < 200) begin
         tick();
         k++;
      end
      start_in = 1'b0;
      while (done !== 1'b1 && k < 400) begin
         tick();
         k++;
      end
      check(done, 1'b1, "command end");
   endtask

   // Six plain reads of the recall sequence with one extra read slipped in
   task automatic plain_seq(input logic [NSQ_ADDR_W-1:0] flip, input int at,
                            input logic [NSQ_ADDR_W-1:0] extra);
      logic [15:0] tbl [0:5] = '{NSQ_PREFIX_0, NSQ_PREFIX_1, NSQ_PREFIX_2, NSQ_PREFIX_3,
                                 NSQ_PREFIX_4, NSQ_CMD_RECALL};
      for (int i = 0; i < 6; i++) begin
         if (i == at) run(NSQ_OP_READ, extra, '0);
         run(NSQ_OP_READ, flip ^ {3'b000, tbl[i]}, '0);
      end
   endtask

   task automatic t_boot;
      int k = 0;
      while (done !== 1'b1 && k < 300) begin
         tick();
         k++;
      end
      check(asave_on, 1'b1, "boot setting");
      check(mem.asave_nv, 1'b1, "saved setting");
      $display("test boot done");
   endtask

   task automatic t_rw;
      run(NSQ_OP_WRITE, 19'h00005, 16'ha5c3);
      run(NSQ_OP_WRITE, 19'h00005, 16'h1111, 2'b10);
      run(NSQ_OP_READ, 19'h00005, '0);
      check(rdata, 16'ha511, "byte write");
      $display("test read write done");
   endtask

   task automatic t_store_recall;
      run(NSQ_OP_STORE, '0, '0);
      check(mem.nv[5], 16'ha511, "stored cell");
      run(NSQ_OP_WRITE, 19'h00005, 16'h0f0f);
      run(NSQ_OP_RECALL, '0, '0);
      run(NSQ_OP_READ, 19'h00005, '0);
      check(rdata, 16'ha511, "recalled cell");
      check(mem.nv[5], 16'ha511, "array after recall");
      $display("test store recall done");
   endtask

   task automatic t_asave;
      run(NSQ_OP_ASAVE_OFF, '0, '0);
      check(asave_on, 1'b0, "host save record");
      check(mem.asave_r, 1'b0, "save off");
      check(mem.asave_nv, 1'b0, "save off kept");
      run(NSQ_OP_ASAVE_ON, '0, '0);
      check(mem.asave_r, 1'b1, "save on");
      check(mem.asave_nv, 1'b1, "save on kept");
      $display("test save setting done");
   endtask

   task automatic t_abort;
      run(NSQ_OP_WRITE, 19'h00009, 16'h1234);
      plain_seq('0, 3, 19'h00009);
      run(NSQ_OP_READ, 19'h00009, '0);
      check(rdata, 16'h1234, "aborted sequence");
      plain_seq(19'h78003, 1, 19'h78003 ^ 19'(NSQ_PREFIX_0));
      run(NSQ_OP_READ, 19'h00009, '0);
      check(rdata, 16'h0000, "restarted recall");
      $display("test abort done");
   endtask

   task automatic t_low;
      run(NSQ_OP_WRITE, 19'h00009, 16'h2222);
      low_supply = 1'b1;
      run(NSQ_OP_WRITE, 19'h00009, 16'hbeef);
      run(NSQ_OP_READ, 19'h00009, '0);
      check(rdata, 16'h2222, "write at low supply");
      run(NSQ_OP_STORE, '0, '0);
      check(mem.nv[9], 16'h0000, "store at low supply");
      low_supply = 1'b0;
      $display("test low supply done");
   endtask

   initial begin
      repeat (10) @(posedge clk_sys_in);
      check(mem.nv[0], 16'h0000, "shipped cell");
      #1;
      srst_in = 1'b0;
      t_boot();
      t_rw();
      t_store_recall();
      t_asave();
      t_abort();
      t_low();
      results();
   end
endmodule // nsq_host_bench

//--- nsq_mem_model.sv
`timescale 1ns/1ps
module nsq_mem_model
   import nsq_pkg::*;
#(
   parameter int BUSY_CYC = 10,
   parameter int LZ_CYC = 2
) (
   input wire logic clk_sys_in,
   input wire logic chip_sel_n_in,
   input wire logic write_en_n_in,
   input wire logic out_en_n_in,
   input wire logic upper_byte_enable_n_in,
   input wire logic lower_byte_enable_n_in,
   input wire logic [NSQ_ADDR_W-1:0] addr_in,
   input wire logic [NSQ_DATA_W-1:0] dq_in,
   output logic [NSQ_DATA_W-1:0] dq_out,
   output logic store_busy_n_out,
   input wire logic low_supply_in
);
   logic [15:0] sram [0:255] = '{default: 16'h0000};
   logic [15:0] nv [0:255] = '{default: 16'h0000};
   logic [15:0] pre [0:4] = '{NSQ_PREFIX_0, NSQ_PREFIX_1, NSQ_PREFIX_2, NSQ_PREFIX_3, NSQ_PREFIX_4};
   logic asave_r = 1'b1;
   logic asave_nv = 1'b1;
   logic sel_q = 1'b1;
   logic we_q = 1'b1;
   logic hiz;
   logic [NSQ_ADDR_W-1:0] addr_q = '0;
   logic [15:0] last_r = 16'h0000;
   int step = 0;
   int busy_cnt = 0;
   int lz_cnt = 0;

   function automatic logic hit(input logic [NSQ_ADDR_W-1:0] a, input logic [15:0] v);
      return a[14:2] == v[14:2];
   endfunction

   assign hiz = step == 5 && (hit(addr_in, NSQ_CMD_STORE) || hit(addr_in, NSQ_CMD_RECALL));
   assign store_busy_n_out = busy_cnt == 0;
   // Undriven bus shows a changing pattern, never the last word
   assign dq_out = (!chip_sel_n_in && !out_en_n_in && write_en_n_in && busy_cnt == 0 && !hiz)
      ? sram[addr_in[7:0]] : ~last_r;

   always @(posedge clk_sys_in) begin
      sel_q <= chip_sel_n_in;
      we_q <= write_en_n_in;
      addr_q <= addr_in;
      if (!$isunknown(dq_out)) last_r <= dq_out;
      if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
      if (busy_cnt == 1) lz_cnt <= LZ_CYC;
      else if (lz_cnt > 0) lz_cnt <= lz_cnt - 1;
      if (!chip_sel_n_in && !write_en_n_in && busy_cnt == 0 && lz_cnt == 0 && !low_supply_in) begin
         if (!upper_byte_enable_n_in) sram[addr_in[7:0]][15:8] <= dq_in[15:8];
         if (!lower_byte_enable_n_in) sram[addr_in[7:0]][7:0] <= dq_in[7:0];
      end
      if (!sel_q && chip_sel_n_in && busy_cnt == 0) begin
         if (we_q && step == 5) begin
            if (hit(addr_q, NSQ_CMD_RECALL)) begin
               sram <= '{default: 16'h0000};
               sram <= nv;
               busy_cnt <= BUSY_CYC;
            end else if (hit(addr_q, NSQ_CMD_STORE) && !low_supply_in) begin
               nv <= sram;
               asave_nv <= asave_r;
               busy_cnt <= BUSY_CYC;
            end else if (hit(addr_q, NSQ_CMD_ASAVE_OFF)) begin
               asave_r <= 1'b0;
            end else if (hit(addr_q, NSQ_CMD_ASAVE_ON)) begin
               asave_r <= 1'b1;
            end
         end
         if (we_q && step < 5 && hit(addr_q, pre[step])) step <= step + 1;
         else step <= (we_q && hit(addr_q, NSQ_PREFIX_0)) ? 1 : 0;
      end
   end
endmodule // nsq_mem_model

//--- nsq_monitor.sv
`timescale 1ns/1ps
module nsq_monitor
   import nsq_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic srst_in,
   input wire logic asave_on_out,
   input wire logic chip_sel_n_out,
   input wire logic write_en_n_out,
   input wire logic out_en_n_out,
   input wire logic [NSQ_ADDR_W-1:0] mem_addr_out,
   input wire logic dq_oe_out,
   input wire logic store_busy_n_in
);
   // ------------------------------------------------------------------
   // Host pin checks
   // ------------------------------------------------------------------
   logic at_pre;
   logic at_store;
   logic at_on;
   assign at_pre = !chip_sel_n_out && mem_addr_out[14:2] == NSQ_PREFIX_0[14:2];
   assign at_store = !chip_sel_n_out && mem_addr_out[14:2] == NSQ_CMD_STORE[14:2];
   assign at_on = !chip_sel_n_out && mem_addr_out[14:2] == NSQ_CMD_ASAVE_ON[14:2];
   default clocking mon_cb @(posedge clk_sys_in);
   endclocking
   default disable iff (srst_in);
   prefix_no_write_a: assert property (at_pre |-> write_en_n_out)
      else $error("write strobe low on a prefix read");
   write_no_read_a: assert property (!write_en_n_out |-> out_en_n_out)
      else $error("output enable low during a write");
   read_no_drive_a: assert property (!out_en_n_out |-> write_en_n_out && !dq_oe_out)
      else $error("host drives data during a read");
   asave_then_store_a: assert property ($changed(asave_on_out) |-> ##[1:60] at_store)
      else $error("no store after a save setting change");
   boot_rewrite_a: assert property ($fell(srst_in) |-> ##[1:40] at_on)
      else $error("save setting not rewritten after reset");
   hold_while_busy_a: assert property (!store_busy_n_in |-> chip_sel_n_out)
      else $error("access while memory busy");
   busy_release_gap_a: assert property ($rose(store_busy_n_in) |-> chip_sel_n_out [*2])
      else $error("access too soon after busy release");
   nv_cmd_float_a: assert property (at_store |-> out_en_n_out)
      else $error("output enable low on store command read");
   cover property (!store_busy_n_in);
   cover property ($fell(asave_on_out));
   cover property (!chip_sel_n_out && !write_en_n_out);
endmodule // nsq_monitor

bind nsq_host nsq_monitor mon (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
   .asave_on_out(asave_on_out), .chip_sel_n_out(chip_sel_n_out),
   .write_en_n_out(write_en_n_out), .out_en_n_out(out_en_n_out),
   .mem_addr_out(mem_addr_out), .dq_oe_out(dq_oe_out), .store_busy_n_in(store_busy_n_in));

//--- nsq_pkg.sv
package nsq_pkg;

   // ------------------------------------------------------------------
   // Widths and sequence
   // ------------------------------------------------------------------
   localparam int NSQ_ADDR_W = 19;
   localparam int NSQ_DATA_W = 16;
   localparam int NSQ_SEQ_LEN = 6;
   localparam int NSQ_STEP_W = 3;

   localparam logic [15:0] NSQ_PREFIX_0 = 16'h4e38;
   localparam logic [15:0] NSQ_PREFIX_1 = 16'hb1c7;
   localparam logic [15:0] NSQ_PREFIX_2 = 16'h83e0;
   localparam logic [15:0] NSQ_PREFIX_3 = 16'h7c1f;
   localparam logic [15:0] NSQ_PREFIX_4 = 16'h703f;
   localparam logic [15:0] NSQ_CMD_STORE = 16'h8fc0;
   localparam logic [15:0] NSQ_CMD_RECALL = 16'h4c63;
   localparam logic [15:0] NSQ_CMD_ASAVE_OFF = 16'h8b45;
   localparam logic [15:0] NSQ_CMD_ASAVE_ON = 16'h4b46;

   // Only bits 14..2 are decoded by the memory
   localparam int NSQ_DEC_HI = 14;
   localparam int NSQ_DEC_LO = 2;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int NSQ_CLK_NS = 50;
   localparam int NSQ_T_ACC_NS = 50;
   localparam int NSQ_T_BUSY_OUT_NS = 100;
   localparam int NSQ_T_RECALL_NS = 200000;
   localparam int NSQ_T_STORE_NS = 8000000;

   localparam int NSQ_ACC_RAW = (NSQ_T_ACC_NS + NSQ_CLK_NS - 1) / NSQ_CLK_NS;
   localparam int NSQ_ACC_CYC = (NSQ_ACC_RAW < 1) ? 1 : NSQ_ACC_RAW;
   localparam int NSQ_BUSY_OUT_RAW = (NSQ_T_BUSY_OUT_NS + NSQ_CLK_NS - 1) / NSQ_CLK_NS;
   localparam int NSQ_BUSY_OUT_CYC = (NSQ_BUSY_OUT_RAW < 1) ? 1 : NSQ_BUSY_OUT_RAW;
   localparam int NSQ_RECALL_CYC = (NSQ_T_RECALL_NS + NSQ_CLK_NS - 1) / NSQ_CLK_NS;
   localparam int NSQ_STORE_CYC = (NSQ_T_STORE_NS + NSQ_CLK_NS - 1) / NSQ_CLK_NS;

   localparam int NSQ_TMR_W = 32;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic NSQ_ASAVE_RST = 1'b1;

   // ------------------------------------------------------------------
   // Commands
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      NSQ_OP_READ,
      NSQ_OP_WRITE,
      NSQ_OP_RECALL,
      NSQ_OP_STORE,
      NSQ_OP_ASAVE_OFF,
      NSQ_OP_ASAVE_ON
   } nsq_op_t;

   // Address of one step of a software sequence
   function automatic logic [NSQ_ADDR_W-1:0] nsq_seq_addr(input logic [NSQ_STEP_W-1:0] step,
                                                          input nsq_op_t op);
      logic [15:0] a;
      a = NSQ_PREFIX_0;
      case (step)
         3'h0: a = NSQ_PREFIX_0;
         3'h1: a = NSQ_PREFIX_1;
         3'h2: a = NSQ_PREFIX_2;
         3'h3: a = NSQ_PREFIX_3;
         3'h4: a = NSQ_PREFIX_4;
         default: begin
            case (op)
               NSQ_OP_STORE: a = NSQ_CMD_STORE;
               NSQ_OP_ASAVE_OFF: a = NSQ_CMD_ASAVE_OFF;
               NSQ_OP_ASAVE_ON: a = NSQ_CMD_ASAVE_ON;
               default: a = NSQ_CMD_RECALL;
            endcase
         end
      endcase
      // Bits 18..16 held at zero, undecoded bits 15 and 1..0 copied from the table word
      nsq_seq_addr = '0;
      nsq_seq_addr[NSQ_DEC_HI:NSQ_DEC_LO] = a[NSQ_DEC_HI:NSQ_DEC_LO];
      nsq_seq_addr[1:0] = a[1:0];
      nsq_seq_addr[15] = a[15];
   endfunction

   function automatic logic nsq_is_seq(input nsq_op_t op);
      nsq_is_seq = (op != NSQ_OP_READ) && (op != NSQ_OP_WRITE);
   endfunction

endpackage
